// file: hw/ssm_motion_top.sv
// Purpose: Step generator, command stack, position and encoder counts
// Assumes: Inputs synchronous to core_clk; synchronous active-low reset
// Notes:   All state lives in one struct registered once per cycle
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Encoder counts up when channel B leads A, down when A leads.
// - Each valid quadrature transition gives a count pulse and direction.
// - Encoder counts are readable any time without disturbing counting.
// - New mode step rate is linear in the value, 1 to 30000.
// - Rate in 1 sps steps, 15000 max with scheduler, 30000 without.
// - Prescaler divides the rate range by 1 up to 256.
// - Top 1-15000, 1-30000 or legacy 1-46250, start 1-13000, slope 0-200 enforced.
// - Reset loads top 4000, start 300, slope 10.
// - Continuous top-speed update takes effect within one step.
// - Signed 32-bit position; narrow query returns low 16 bits.
// - Full position query returns the whole 32-bit signed value.
// - Relative moves add to the position and never clear it.
// - Eight-deep command stack, next command starts within one step.
// - Last direction reads minus toward home, plus toward limit.
// - Continuous with soft limits and zero slope is rejected.
// - Continuous top update ignored if slope 0, start equals top, limit, no scheduler.
// - Acceleration and deceleration are linear, slope at most 200.
// - Legacy mode: each rate unit is one 0.5425347 us tick.
// - Legacy 46250 is fastest; each decrement adds one tick.
// - Legacy period is (46379 minus value) ticks.
// - Legacy prescaler multiplies the tick by prescale plus one.
// - Control bit reverses the phase drive order for all moves.
// - Target above position drives toward limit, below toward home.
// - Zero slope runs the whole move at one fixed rate.
module ssm_motion_top #(
    parameter int NENC     = 2,
    parameter bit WIDE_POS = 1'b0,
    parameter int QDEPTH   = 8
)(
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic [3:0]      regAddr,
    input  wire logic [31:0]     regWrData,
    input  wire logic            regWr,
    input  wire logic            regRd,
    output logic [31:0]          regRdData,
    input  wire logic [NENC-1:0] encChA,
    input  wire logic [NENC-1:0] encChB,
    output logic                 stepPulse,
    output logic                 stepDirUp,
    output logic [3:0]           phaseDrive,
    output logic                 moving
);
    localparam int QW = $clog2(QDEPTH);
    typedef struct packed {
        logic [15:0]                  ctrl, top, start;
        logic [7:0]                   slope;
        logic [31:0]                  limit;
        ssm_pkg::ssm_cmd_type [QDEPTH-1:0] cq;
        logic [QW-1:0]                wp;
        logic [QW-1:0]                rp;
        logic [QW:0]                  cnt;
        ssm_pkg::ssm_run_type         run;
        logic                         cont, dirUp, limTrip, err, lastPlus, mov;
        logic [31:0]                  target, pos;
        logic [15:0]                  cur;
        logic [15:0]                  accSteps;
        logic [7:0]                   preCnt;
        logic [31:0]                  acc, tickAcc;
        logic [15:0]                  legCnt;
        logic [1:0]                   phIdx;
        logic [3:0]                   phaseQ;
        logic                         stepQ;
        logic [31:0]                  rdData;
        logic [NENC-1:0][1:0]         encPrev;
        logic [NENC-1:0][31:0]        enc;
    } ssm_state_type;
    ssm_state_type q;
    ssm_state_type d;
    logic              preEn, stepNow, push, pop, errSet, limHit, contBlock;
    logic [31:0]       topMax, sum, nextPos, rem, tgt;
    logic [16:0]       up, dn;
    logic [1:0]        encNow;
    logic [NENC-1:0]   encPulse, encUp;
    ssm_pkg::ssm_cmd_type head;
    function automatic logic inRange(input logic [31:0] v,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction
    always_comb
    begin
        d         = q;
        d.stepQ   = 1'b0;
        preEn     = 1'b0;
        stepNow   = 1'b0;
        push      = 1'b0;
        pop       = 1'b0;
        errSet    = 1'b0;
        limHit    = 1'b0;
        sum       = ssm_pkg::ZERO32;
        nextPos   = q.pos;
        rem       = ssm_pkg::ZERO32;
        tgt       = ssm_pkg::ZERO32;
        up        = {1'b0, q.cur} + {9'h0_00, q.slope};
        dn        = {1'b0, q.cur} - {9'h0_00, q.slope};
        encNow    = 2'b00;
        encPulse  = '0;
        encUp     = '0;
        head      = q.cq[q.rp];
        topMax    = q.ctrl[ssm_pkg::C_LEGACY] ? ssm_pkg::TOP_MAX_LEG :
                    q.ctrl[ssm_pkg::C_SCHED]  ? ssm_pkg::TOP_MAX_ON  :
                                                ssm_pkg::TOP_MAX_OFF;
        contBlock = (q.slope == 8'h00) || (q.start == q.top) ||
                    q.limTrip || !q.ctrl[ssm_pkg::C_SCHED];
        // Quadrature decode per channel pair
        for (int i = 0; i < NENC; i++)
        begin
            encNow = {encChA[i], encChB[i]};
            if ((encNow ^ q.encPrev[i]) == 2'b01 ||
                (encNow ^ q.encPrev[i]) == 2'b10)
            begin
                encPulse[i] = 1'b1;
                encUp[i] = q.encPrev[i][1] ^ encNow[0];
                d.enc[i] = encUp[i] ? q.enc[i] + 32'h0000_0001
                                    : q.enc[i] - 32'h0000_0001;
            end
            d.encPrev[i] = encNow;
        end
        // Register writes
        if (regWr)
        begin
            case (regAddr)
                ssm_pkg::A_CTRL:  d.ctrl = regWrData[15:0];
                ssm_pkg::A_TOP:
                    if (!inRange(regWrData, ssm_pkg::VAL_MIN, topMax))
                        errSet = 1'b1;
                    else if (!(q.cont && q.run != ssm_pkg::R_IDLE &&
                               contBlock))
                        d.top = regWrData[15:0];
                ssm_pkg::A_START:
                    if (inRange(regWrData, ssm_pkg::VAL_MIN,
                                ssm_pkg::START_MAX))
                        d.start = regWrData[15:0];
                    else
                        errSet = 1'b1;
                ssm_pkg::A_SLOPE:
                    if (inRange(regWrData, ssm_pkg::ZERO32,
                                ssm_pkg::SLOPE_MAX))
                        d.slope = regWrData[7:0];
                    else
                        errSet = 1'b1;
                ssm_pkg::A_LIMIT: d.limit = regWrData;
                ssm_pkg::A_CABS, ssm_pkg::A_CREL, ssm_pkg::A_CCONT:
                    if (q.cnt == (QW+1)'(QDEPTH))
                        errSet = 1'b1;
                    else
                        push = 1'b1;
                ssm_pkg::A_STOP:
                    if (q.run != ssm_pkg::R_IDLE)
                        d.run = (q.slope == 8'h00) ? ssm_pkg::R_IDLE
                                                   : ssm_pkg::R_DECEL;
                default: ;
            endcase
        end
        if (push)
        begin
            d.cq[q.wp].kind = (regAddr == ssm_pkg::A_CABS) ? ssm_pkg::K_ABS :
                              (regAddr == ssm_pkg::A_CREL) ? ssm_pkg::K_REL :
                                                             ssm_pkg::K_CONT;
            d.cq[q.wp].data = regWrData;
            d.wp = q.wp + 1'b1;
        end
        // Prescaler enable
        if (q.preCnt == q.ctrl[ssm_pkg::C_PRE +: 8])
        begin
            preEn    = 1'b1;
            d.preCnt = 8'h00;
        end
        else
            d.preCnt = q.preCnt + 8'h01;
        unique case (q.run)
            ssm_pkg::R_IDLE:
            begin
                if (q.cnt != '0)
                begin
                    pop = 1'b1;
                    tgt = (head.kind == ssm_pkg::K_REL) ?
                          q.pos + head.data : head.data;
                    d.acc     = ssm_pkg::ZERO32;
                    d.tickAcc = ssm_pkg::ZERO32;
                    d.legCnt  = 16'h0000;
                    d.accSteps = 16'h0000;
                    d.limTrip = 1'b0;
                    d.cur = (q.slope == 8'h00) ? q.top : q.start;
                    d.target = tgt;
                    if (head.kind == ssm_pkg::K_CONT)
                    begin
                        if (q.ctrl[ssm_pkg::C_SOFTL] && q.slope == 8'h00)
                            errSet = 1'b1;
                        else
                        begin
                            d.run = ssm_pkg::R_RUN;
                            d.cont = 1'b1;
                            d.dirUp = head.data[0];
                            d.lastPlus = head.data[0];
                        end
                    end
                    else if (tgt != q.pos)
                    begin
                        d.run = ssm_pkg::R_RUN;
                        d.cont = 1'b0;
                        d.dirUp = $signed(tgt) > $signed(q.pos);
                        d.lastPlus = $signed(tgt) > $signed(q.pos);
                    end
                end
            end
            ssm_pkg::R_RUN, ssm_pkg::R_DECEL:
            begin
                if (preEn && !q.ctrl[ssm_pkg::C_LEGACY])
                begin
                    sum = q.acc + {16'h0000, q.cur};
                    if (sum >= ssm_pkg::CLK_HZ)
                    begin
                        stepNow = 1'b1;
                        d.acc = sum - ssm_pkg::CLK_HZ;
                    end
                    else
                        d.acc = sum;
                end
                if (preEn && q.ctrl[ssm_pkg::C_LEGACY])
                begin
                    sum = q.tickAcc + ssm_pkg::CLK_E4NS;
                    d.tickAcc = sum;
                    if (sum >= ssm_pkg::TICK_E4NS)
                    begin
                        d.tickAcc = sum - ssm_pkg::TICK_E4NS;
                        if ({1'b0, q.legCnt} + 17'h0_0001 >=
                            ssm_pkg::LEG_BASE - {1'b0, q.cur})
                        begin
                            stepNow = 1'b1;
                            d.legCnt = 16'h0000;
                        end
                        else
                            d.legCnt = q.legCnt + 16'h0001;
                    end
                end
            end
            default: d.run = ssm_pkg::R_IDLE;
        endcase
        if (stepNow)
        begin
            d.stepQ = 1'b1;
            nextPos = q.dirUp ? q.pos + 32'h0000_0001
                              : q.pos - 32'h0000_0001;
            d.pos = nextPos;
            d.phIdx = (q.dirUp ^ q.ctrl[ssm_pkg::C_PHREV]) ?
                      q.phIdx + 2'b01 : q.phIdx - 2'b01;
            d.phaseQ = ssm_pkg::PHASE_SEQ[d.phIdx];
            rem = q.dirUp ? q.target - nextPos : nextPos - q.target;
            if (q.cont && q.ctrl[ssm_pkg::C_SOFTL])
                limHit = q.dirUp ?
                    $signed(q.limit - nextPos) <= $signed({16'h0, q.accSteps})
                  : $signed(nextPos) <= $signed({16'h0, q.accSteps});
            if (!q.cont && nextPos == q.target)
                d.run = ssm_pkg::R_IDLE;
            else if (q.run == ssm_pkg::R_RUN)
            begin
                if (limHit && q.slope == 8'h00)
                    d.run = ssm_pkg::R_IDLE;
                else if (limHit || (!q.cont && q.slope != 8'h00 &&
                         rem <= {16'h0000, q.accSteps}))
                begin
                    d.run = ssm_pkg::R_DECEL;
                    d.limTrip = q.limTrip | limHit;
                end
                else if (q.cur < q.top)
                begin
                    d.cur = (up > {1'b0, q.top}) ? q.top : up[15:0];
                    d.accSteps = q.accSteps + 16'h0001;
                end
                else if (q.cur > q.top)
                begin
                    d.cur = (dn < {1'b0, q.top} || dn[16]) ? q.top
                                                           : dn[15:0];
                    if (q.accSteps != 16'h0000)
                        d.accSteps = q.accSteps - 16'h0001;
                end
            end
            else
            begin
                d.cur = (dn < {1'b0, q.start} || dn[16]) ? q.start
                                                         : dn[15:0];
                if (q.accSteps != 16'h0000)
                    d.accSteps = q.accSteps - 16'h0001;
                if (q.cont && q.accSteps == 16'h0000)
                    d.run = ssm_pkg::R_IDLE;
            end
        end
        if (pop)
            d.rp = q.rp + 1'b1;
        d.cnt = q.cnt + (QW+1)'(push) - (QW+1)'(pop);
        // Register reads, answered next cycle
        d.rdData = ssm_pkg::ZERO32;
        if (regRd)
        begin
            case (regAddr)
                ssm_pkg::A_CTRL:  d.rdData = {16'h0000, q.ctrl};
                ssm_pkg::A_TOP:   d.rdData = {16'h0000, q.top};
                ssm_pkg::A_START: d.rdData = {16'h0000, q.start};
                ssm_pkg::A_SLOPE: d.rdData = {24'h00_0000, q.slope};
                ssm_pkg::A_LIMIT: d.rdData = q.limit;
                ssm_pkg::A_POS:   d.rdData = WIDE_POS ? q.pos
                                    : {16'h0000, q.pos[15:0]};
                ssm_pkg::A_POSF:  d.rdData = q.pos;
                ssm_pkg::A_LDIR:  d.rdData = {24'h00_0000,
                    q.lastPlus ? ssm_pkg::CH_PLUS : ssm_pkg::CH_MINUS};
                ssm_pkg::A_STAT:
                begin
                    d.rdData[ssm_pkg::S_ACT]  = q.run != ssm_pkg::R_IDLE;
                    d.rdData[ssm_pkg::S_CONT] = q.cont;
                    d.rdData[ssm_pkg::S_LIMT] = q.limTrip;
                    d.rdData[ssm_pkg::S_ERR]  = q.err;
                    d.rdData[ssm_pkg::S_CNT +: QW+1] = q.cnt;
                end
                default:
                    for (int i = 0; i < NENC; i++)
                        if (regAddr == ssm_pkg::A_ENC0 + 4'(i))
                            d.rdData = q.enc[i];
            endcase
        end
        d.err = errSet ||
                (q.err && !(regRd && regAddr == ssm_pkg::A_STAT));
        if (!rst_n)
        begin
            d       = '0;
            d.ctrl  = ssm_pkg::CTRL_RST;
            d.top   = ssm_pkg::TOP_RST[15:0];
            d.start = ssm_pkg::START_RST[15:0];
            d.slope = ssm_pkg::SLOPE_RST[7:0];
            d.lastPlus = 1'b1;
            d.phaseQ = ssm_pkg::PHASE_SEQ[0];
        end
        d.mov = d.run != ssm_pkg::R_IDLE;
    end
    always_ff @(posedge core_clk)
    begin
        q <= d;
    end
    assign regRdData  = q.rdData;
    assign stepPulse  = q.stepQ;
    assign stepDirUp  = q.dirUp;
    assign phaseDrive = q.phaseQ;
    assign moving     = q.mov;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_step_moves_pos: assert property (
        q.stepQ |-> q.pos == $past(q.pos) +
                   (q.dirUp ? 32'h0000_0001 : 32'hffff_ffff))
        else $error("position did not follow step");
    a_enc_b_leads: assert property (
        encChA[0] == q.encPrev[0][1] && encChB[0] != q.encPrev[0][0] &&
        (q.encPrev[0][1] ^ encChB[0]) |=> q.enc[0] == $past(q.enc[0]) + 1)
        else $error("B-leading edge did not count up");
    a_pos_full_read: assert property (
        regRd && regAddr == ssm_pkg::A_POSF |=> regRdData == $past(q.pos))
        else $error("full position read wrong");
    a_pos_low_read: assert property (
        regRd && regAddr == ssm_pkg::A_POS && !WIDE_POS
        |=> regRdData == {16'h0000, $past(q.pos[15:0])})
        else $error("narrow position read wrong");
    a_top_in_range: assert property (
        q.top >= 16'h0001 && q.start <= ssm_pkg::START_MAX[15:0] &&
        q.slope <= ssm_pkg::SLOPE_MAX[7:0])
        else $error("parameter outside accepted range");
    a_reset_values: assert property (
        $rose(rst_n) |-> q.top == ssm_pkg::TOP_RST[15:0] &&
        q.start == ssm_pkg::START_RST[15:0] && q.slope == 8'h0a)
        else $error("power-up values wrong");
    a_cont_reject: assert property (
        q.run == ssm_pkg::R_IDLE && q.cnt != '0 &&
        q.cq[q.rp].kind == ssm_pkg::K_CONT &&
        q.ctrl[ssm_pkg::C_SOFTL] && q.slope == 8'h00
        |=> q.err && q.run == ssm_pkg::R_IDLE)
        else $error("continuous move not rejected");
    a_slope0_fixed: assert property (
        q.stepQ && q.slope == 8'h00 && $past(q.run) != ssm_pkg::R_IDLE
        |-> q.cur == $past(q.cur))
        else $error("rate changed with zero slope");
    a_queue_depth: assert property (
        q.cnt <= (QW+1)'(QDEPTH))
        else $error("command stack overflow");

    c_step: cover property (q.stepQ ##1 !q.stepQ);
    c_enc_count: cover property (encPulse[0] && !encUp[0]);
    c_cont_run: cover property (q.cont && q.run == ssm_pkg::R_DECEL);
endmodule

// file: hw/ssm_pkg.sv
// Purpose: Shared constants and types for the stepper motion block
// Assumes: 40 MHz core clock, word-indexed register port
// Notes:   Times are kept in their own units; cycle counts derive
package ssm_pkg;
    // Register indexes
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_TOP    = 4'h1;
    localparam logic [3:0] A_START  = 4'h2;
    localparam logic [3:0] A_SLOPE  = 4'h3;
    localparam logic [3:0] A_LIMIT  = 4'h4;
    localparam logic [3:0] A_CABS   = 4'h5;
    localparam logic [3:0] A_CREL   = 4'h6;
    localparam logic [3:0] A_CCONT  = 4'h7;
    localparam logic [3:0] A_STOP   = 4'h8;
    localparam logic [3:0] A_POS    = 4'h9;
    localparam logic [3:0] A_POSF   = 4'ha;
    localparam logic [3:0] A_LDIR   = 4'hb;
    localparam logic [3:0] A_STAT   = 4'hc;
    localparam logic [3:0] A_ENC0   = 4'hd;
    // Control field positions
    localparam int C_LEGACY = 0;
    localparam int C_SCHED  = 1;
    localparam int C_SOFTL  = 2;
    localparam int C_PHREV  = 3;
    localparam int C_PRE    = 8;
    localparam logic [15:0] CTRL_RST = 16'h0002;
    // Status field positions
    localparam int S_ACT  = 0;
    localparam int S_CONT = 1;
    localparam int S_LIMT = 2;
    localparam int S_ERR  = 3;
    localparam int S_CNT  = 4;
    // Power-up values and accepted ranges
    localparam logic [31:0] TOP_RST     = 32'h0000_0fa0;
    localparam logic [31:0] START_RST   = 32'h0000_012c;
    localparam logic [31:0] SLOPE_RST   = 32'h0000_000a;
    localparam logic [31:0] TOP_MAX_ON  = 32'h0000_3a98;
    localparam logic [31:0] TOP_MAX_OFF = 32'h0000_7530;
    localparam logic [31:0] TOP_MAX_LEG = 32'h0000_b4aa;
    localparam logic [31:0] START_MAX   = 32'h0000_32c8;
    localparam logic [31:0] SLOPE_MAX   = 32'h0000_00c8;
    localparam logic [31:0] VAL_MIN     = 32'h0000_0001;
    localparam logic [31:0] ZERO32      = 32'h0000_0000;
    // Timing: clock, legacy tick in units of 0.1 ps, legacy base
    localparam logic [31:0] CLK_HZ      = 32'h0262_5a00;
    localparam logic [31:0] CLK_E4NS    = 32'h0003_d090;
    localparam logic [31:0] TICK_E4NS   = 32'h0052_c8c3;
    localparam logic [16:0] LEG_BASE    = 17'h0_b52b;
    // Answer characters
    localparam logic [7:0] CH_PLUS  = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    // Full-step phase drive order
    localparam logic [3:0][3:0] PHASE_SEQ =
        {4'h9, 4'h5, 4'h6, 4'ha};
    typedef enum logic [1:0] {
        K_ABS  = 2'b00,
        K_REL  = 2'b01,
        K_CONT = 2'b10
    } ssm_kind_type;
    typedef enum logic [1:0] {
        R_IDLE  = 2'b00,
        R_RUN   = 2'b01,
        R_DECEL = 2'b10
    } ssm_run_type;
    typedef struct packed {
        ssm_kind_type kind;
        logic [31:0]  data;
    } ssm_cmd_type;
endpackage

// file: verif/ssm_enc_model.sv
// Purpose: Quadrature encoder model for the motion bench
// Assumes: One step request per pulse of stepReq
// Notes:   Gray order 00,01,11,10 means channel B leads
`timescale 1ns/1ps
module ssm_enc_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic stepReq,
    input  wire logic stepUp,
    output logic      chA,
    output logic      chB
);
    logic [1:0] ph_q;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ph_q <= 2'h0;
        else if (stepReq)
            ph_q <= stepUp ? ph_q + 2'h1 : ph_q - 2'h1;
    end
    assign chA = ph_q[1];
    assign chB = ph_q[1] ^ ph_q[0];
endmodule

// file: verif/stepper_motion_and_quadrature_counter_bench.sv
// Purpose: Self-checking bench for the stepper motion block
// Assumes: 40 MHz clock, one encoder channel pair
// Notes:   Random counts from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module stepper_motion_and_quadrature_counter_bench;
    logic        core_clk, rst_n, regWr, regRd, encReq, encUp, encA, encB;
    logic        stepPulse, stepDirUp, moving, dirSeen;
    logic [3:0]  regAddr, phaseDrive;
    logic [31:0] regWrData, regRdData, rv;
    int          fails = 0, n_checks = 0, seed = 62544, nSteps = 0;
    int          gap = 0, last = 0, cyc = 0, k, n, m, s0;
    ssm_motion_top #(.NENC(1)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .encChA(encA), .encChB(encB),
        .stepPulse(stepPulse), .stepDirUp(stepDirUp),
        .phaseDrive(phaseDrive), .moving(moving));
    ssm_enc_model enc_u (.core_clk(core_clk), .rst_n(rst_n),
        .stepReq(encReq), .stepUp(encUp), .chA(encA), .chB(encB));
    function automatic int period(input int r);
        return 40000000 / r;
    endfunction
    function automatic logic [3:0] phase_of(input int i);
        return (i % 4 == 0) ? 4'ha : (i % 4 == 1) ? 4'h6 :
               (i % 4 == 2) ? 4'h5 : 4'h9;
    endfunction
    task give_verdict;
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a; regWrData <= d; regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        rv = regRdData;
    endtask
    task enc(input logic up, input int c);
        repeat (c)
        begin
            @(posedge core_clk);
            encReq <= 1'b1; encUp <= up;
            @(posedge core_clk);
            encReq <= 1'b0;
        end
    endtask
    task move(input logic [31:0] d);
        s0 = nSteps;
        wr(ssm_pkg::A_CREL, d);
        repeat (3) @(posedge core_clk);
        for (k = 0; k < 30000 && moving !== 1'b0; k++)
            @(posedge core_clk);
        @(negedge core_clk);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (stepPulse === 1'b1)
        begin
            nSteps <= nSteps + 1; gap <= cyc - last; last <= cyc;
            dirSeen <= stepDirUp;
        end
    end
    initial
    begin
        #(25 * 60000); fails++; give_verdict;
    end
    initial
    begin
        rst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0;
        regWrData = 32'h0000_0000; encReq = 1'b0; encUp = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ssm_pkg::A_TOP); `CHK("top", 32'h0000_0fa0, rv)
        rd(ssm_pkg::A_START); `CHK("start", 32'h0000_012c, rv)
        rd(ssm_pkg::A_SLOPE); `CHK("slope", 32'h0000_000a, rv)
        rd(ssm_pkg::A_LDIR); `CHK("ldir", 32'h0000_002b, rv)
        rd(4'hf); `CHK("unmapped", 32'h0000_0000, rv)
        wr(ssm_pkg::A_TOP, 32'h0000_3a99);
        rd(ssm_pkg::A_TOP); `CHK("topmax", 32'h0000_0fa0, rv)
        wr(ssm_pkg::A_SLOPE, 32'h0000_00c9);
        rd(ssm_pkg::A_SLOPE); `CHK("slopemax", 32'h0000_000a, rv)
        wr(ssm_pkg::A_SLOPE, 32'h0000_0000);
        wr(ssm_pkg::A_TOP, 32'h0000_3a98);
        n = {$random(seed)} % 8 + 3;
        enc(1'b1, n);
        rd(ssm_pkg::A_ENC0); `CHK("encup", n, rv)
        enc(1'b0, 2);
        rd(ssm_pkg::A_ENC0); `CHK("encdn", n - 2, rv)
        m = {$random(seed)} % 3 + 2;
        move(m);
        `CHK("steps", m, nSteps - s0)
        `CHK("dirup", 1'b1, dirSeen)
        `CHK("rate", 1'b1, gap - period(15000) inside {0, 1})
        rd(ssm_pkg::A_POSF); `CHK("posf", m, rv)
        move(32'hffff_ffff);
        rd(ssm_pkg::A_POS); `CHK("pos", m - 1, rv)
        `CHK("dirdn", 1'b0, dirSeen)
        rd(ssm_pkg::A_LDIR); `CHK("ldir2", 32'h0000_002d, rv)
        `CHK("phase", phase_of(m - 1), phaseDrive)
        wr(ssm_pkg::A_CTRL, 32'h0000_000a);
        move(32'h0000_0001);
        `CHK("phrev", phase_of(m - 2), phaseDrive)
        `CHK("phrevdir", 1'b1, dirSeen)
        wr(ssm_pkg::A_CTRL, 32'h0000_0006);
        wr(ssm_pkg::A_CCONT, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        rd(ssm_pkg::A_STAT); `CHK("conterr", 1'b1, rv[3])
        `CHK("contidle", 1'b0, moving)
        give_verdict;
    end
endmodule
